// ### logic/pep_pkg.sv
// Constants, field layout and carrier types of the PHY port event and status registers
package pep_pkg;

  // Register byte addresses on the management port
  localparam logic [15:0] PEP_ADDR_IRQ = 16'h0136;
  localparam logic [15:0] PEP_ADDR_XOVER = 16'h0138;
  localparam logic [15:0] PEP_ADDR_PHYCTL = 16'h013E;

  // Bus widths and event count
  localparam int PEP_AW = 16;
  localparam int PEP_DW = 16;
  localparam int PEP_NEV = 8;

  // Interrupt control / status field positions
  localparam int PEP_IRQ_EN_LSB = 8;
  localparam int PEP_IRQ_EN_MSB = 15;
  localparam int PEP_IRQ_ST_LSB = 0;
  localparam int PEP_IRQ_ST_MSB = 7;

  // Crossover select field positions
  localparam int PEP_XO_FORCE_BIT = 7;
  localparam int PEP_XO_DIS_BIT = 6;

  // PHY control field positions
  localparam int PEP_PC_RSVHI_LSB = 12;
  localparam int PEP_PC_RSVHI_MSB = 15;
  localparam int PEP_PC_JAB_BIT = 9;
  localparam int PEP_PC_RSV87_LSB = 7;
  localparam int PEP_PC_RSV87_MSB = 8;
  localparam int PEP_PC_SPD100_BIT = 5;
  localparam int PEP_PC_SPD10_BIT = 4;
  localparam int PEP_PC_DUP_BIT = 3;

  // Reset values
  localparam logic [7:0] PEP_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] PEP_IRQ_ST_RST = 8'h00;
  localparam logic [15:0] PEP_XO_RST = 16'h0000;
  localparam logic PEP_JAB_RST = 1'b1;
  localparam logic [1:0] PEP_RSV87_RST = 2'h2;
  localparam logic [3:0] PEP_RSVHI_RST = 4'h0;
  localparam logic [15:0] PEP_RD_IDLE = 16'h0000;

  // Event pulses from the PHY, in status bit order 7 down to 0
  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_rx;
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } pep_event_t;

  // Resolved link state from the PHY
  typedef struct packed {
    logic speed_100;
    logic speed_10;
    logic full_duplex;
  } pep_link_t;

  // One management port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pep_bus_req_t;

endpackage

// ### logic/pep_event_latch.sv
// Sticky event status bits with read clear, one flip-flop per event
`timescale 1ns/1ps
`default_nettype none

module pep_event_latch (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] event_pulse,
  input wire logic clear_req,
  output logic [7:0] status_reg
);

  genvar gi;

  // Each bit sets on its pulse; clear only drops bits already captured
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          status_reg[gi] <= pep_pkg::PEP_IRQ_ST_RST[gi];
        end else if (event_pulse[gi]) begin
          status_reg[gi] <= 1'b1;
        end else if (clear_req) begin
          status_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### logic/pep_phy_port_regs.sv
// Per-port PHY event interrupt, crossover select and PHY control registers
`timescale 1ns/1ps
`default_nettype none

module pep_phy_port_regs (
  input wire logic core_clk,
  input wire logic resetn,
  input wire pep_pkg::pep_bus_req_t bus_req,
  output logic [15:0] rd_data,
  input wire pep_pkg::pep_event_t phy_events,
  input wire pep_pkg::pep_link_t link_status,
  output logic irq,
  output logic auto_crossover_en,
  output logic forced_crossover_select,
  output logic crossover_force_mdi,
  output logic crossover_force_mdix,
  output logic jabber_count_en
);

  // Address match, shared by the write and read decoders
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
    addr_hit = (addr == target);
  endfunction

  // Strobe qualified by address
  function automatic logic strobe_hit(input logic strobe, input logic [15:0] addr,
                                      input logic [15:0] target);
    strobe_hit = strobe & addr_hit(addr, target);
  endfunction

  // Register state
  logic [7:0] irq_en_reg;
  logic [7:0] irq_st_reg;
  logic [15:0] xover_reg;
  logic jabber_en_reg;
  logic [1:0] rsv87_reg;
  logic [3:0] rsvhi_reg;
  logic [15:0] rd_data_reg;
  logic [15:0] rd_data_next;
  logic irq_reg;
  logic irq_next;

  // Decoded strobes
  logic wr_irq;
  logic wr_xover;
  logic wr_phyctl;
  logic rd_irq;
  logic rd_any;

  // Assembled read views
  logic [15:0] irq_view;
  logic [15:0] xover_view;
  logic [15:0] phyctl_view;

  // Write and read decode
  assign wr_irq = strobe_hit(bus_req.wr, bus_req.addr, pep_pkg::PEP_ADDR_IRQ);
  assign wr_xover = strobe_hit(bus_req.wr, bus_req.addr, pep_pkg::PEP_ADDR_XOVER);
  assign wr_phyctl = strobe_hit(bus_req.wr, bus_req.addr, pep_pkg::PEP_ADDR_PHYCTL);
  assign rd_irq = strobe_hit(bus_req.rd, bus_req.addr, pep_pkg::PEP_ADDR_IRQ);
  assign rd_any = bus_req.rd;

  // Interrupt enables; status half of a write is dropped, those bits are read-only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_reg <= pep_pkg::PEP_IRQ_EN_RST;
    end else if (wr_irq) begin
      irq_en_reg <= bus_req.wdata[pep_pkg::PEP_IRQ_EN_MSB:pep_pkg::PEP_IRQ_EN_LSB];
    end
  end

  // Sticky event bits; an event in the clearing read's cycle survives
  pep_event_latch u_event_latch (
    .core_clk(core_clk),
    .resetn(resetn),
    .event_pulse(phy_events),
    .clear_req(rd_irq),
    .status_reg(irq_st_reg)
  );

  // Crossover select; reserved bits are plain storage and read back
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xover_reg <= pep_pkg::PEP_XO_RST;
    end else if (wr_xover) begin
      xover_reg <= bus_req.wdata;
    end
  end

  // Jabber counter enable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      jabber_en_reg <= pep_pkg::PEP_JAB_RST;
    end else if (wr_phyctl) begin
      jabber_en_reg <= bus_req.wdata[pep_pkg::PEP_PC_JAB_BIT];
    end
  end

  // Writable reserved fields of the PHY control register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsv87_reg <= pep_pkg::PEP_RSV87_RST;
      rsvhi_reg <= pep_pkg::PEP_RSVHI_RST;
    end else if (wr_phyctl) begin
      rsv87_reg <= bus_req.wdata[pep_pkg::PEP_PC_RSV87_MSB:pep_pkg::PEP_PC_RSV87_LSB];
      rsvhi_reg <= bus_req.wdata[pep_pkg::PEP_PC_RSVHI_MSB:pep_pkg::PEP_PC_RSVHI_LSB];
    end
  end

  // Interrupt control / status view
  always_comb begin
    irq_view = 16'h0000;
    irq_view[pep_pkg::PEP_IRQ_EN_MSB:pep_pkg::PEP_IRQ_EN_LSB] = irq_en_reg;
    irq_view[pep_pkg::PEP_IRQ_ST_MSB:pep_pkg::PEP_IRQ_ST_LSB] = irq_st_reg;
  end

  // Crossover view is the stored word
  assign xover_view = xover_reg;

  // PHY control view; latching reserved bits have no source and read zero
  always_comb begin
    phyctl_view = 16'h0000;
    phyctl_view[pep_pkg::PEP_PC_RSVHI_MSB:pep_pkg::PEP_PC_RSVHI_LSB] = rsvhi_reg;
    phyctl_view[pep_pkg::PEP_PC_JAB_BIT] = jabber_en_reg;
    phyctl_view[pep_pkg::PEP_PC_RSV87_MSB:pep_pkg::PEP_PC_RSV87_LSB] = rsv87_reg;
    phyctl_view[pep_pkg::PEP_PC_SPD100_BIT] = link_status.speed_100;
    phyctl_view[pep_pkg::PEP_PC_SPD10_BIT] = link_status.speed_10;
    phyctl_view[pep_pkg::PEP_PC_DUP_BIT] = link_status.full_duplex;
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rd_data_next = pep_pkg::PEP_RD_IDLE;
    if (rd_any) begin
      if (addr_hit(bus_req.addr, pep_pkg::PEP_ADDR_IRQ)) begin
        rd_data_next = irq_view;
      end else if (addr_hit(bus_req.addr, pep_pkg::PEP_ADDR_XOVER)) begin
        rd_data_next = xover_view;
      end else if (addr_hit(bus_req.addr, pep_pkg::PEP_ADDR_PHYCTL)) begin
        rd_data_next = phyctl_view;
      end
    end
  end

  // Read data captured on the strobe edge, so the status word is the pre-clear value
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_reg <= pep_pkg::PEP_RD_IDLE;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;

  // Level request from enabled status bits
  assign irq_next = |(irq_st_reg & irq_en_reg);

  // Registered so the output is glitch free; lags the status bits by one cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

  // Crossover controls; forced choice only counts with automatic mode off
  assign auto_crossover_en = ~xover_reg[pep_pkg::PEP_XO_DIS_BIT];
  assign forced_crossover_select = xover_reg[pep_pkg::PEP_XO_FORCE_BIT];
  assign crossover_force_mdi = xover_reg[pep_pkg::PEP_XO_DIS_BIT] &
                               xover_reg[pep_pkg::PEP_XO_FORCE_BIT];
  assign crossover_force_mdix = xover_reg[pep_pkg::PEP_XO_DIS_BIT] &
                                ~xover_reg[pep_pkg::PEP_XO_FORCE_BIT];

  // Jabber counter gate for the PHY datapath
  assign jabber_count_en = jabber_en_reg;

endmodule

`default_nettype wire

// ### tb/pep_phy_port_regs_monitor.sv
// Port-level assertions for the PHY port event and status registers
`timescale 1ns/1ps
`default_nettype none
module pep_phy_port_regs_monitor (
  input wire logic core_clk,
  input wire logic resetn,
  input wire pep_pkg::pep_bus_req_t bus_req,
  input wire logic [15:0] rd_data,
  input wire pep_pkg::pep_event_t phy_events,
  input wire pep_pkg::pep_link_t link_status,
  input wire logic irq,
  input wire logic auto_crossover_en,
  input wire logic forced_crossover_select,
  input wire logic crossover_force_mdi,
  input wire logic crossover_force_mdix,
  input wire logic jabber_count_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Decoded requests
  wire logic rd_irq = bus_req.rd && bus_req.addr == pep_pkg::PEP_ADDR_IRQ;
  wire logic rd_pc = bus_req.rd && bus_req.addr == pep_pkg::PEP_ADDR_PHYCTL;
  wire logic wr_irq = bus_req.wr && bus_req.addr == pep_pkg::PEP_ADDR_IRQ;
  wire logic wr_xo = bus_req.wr && bus_req.addr == pep_pkg::PEP_ADDR_XOVER;
  wire logic wr_pc = bus_req.wr && bus_req.addr == pep_pkg::PEP_ADDR_PHYCTL;
  property p_rd_idle; !bus_req.rd |=> rd_data == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  // Second read sees only events that landed during the first
  property p_st_rd; rd_irq ##1 rd_irq |=> rd_data[7:0] == $past(phy_events, 2); endproperty
  a_st_rd: assert property (p_st_rd) else $error("status not cleared by read");
  property p_pc_rd; rd_pc |=> rd_data[5:3] == $past(link_status); endproperty
  a_pc_rd: assert property (p_pc_rd) else $error("link status wrong");
  property p_irq_clr; rd_irq && phy_events == 8'h00 |=> ##1 !irq; endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq held after clear");
  // A rise needs an event or an enable write two edges back
  property p_irq_rise; $rose(irq) |-> $past(|phy_events, 2) || $past(wr_irq, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_xo_out;
    crossover_force_mdi == (!auto_crossover_en && forced_crossover_select) &&
      crossover_force_mdix == (!auto_crossover_en && !forced_crossover_select);
  endproperty
  a_xo_out: assert property (p_xo_out) else $error("forced mode wrong");
  property p_xo_wr;
    wr_xo |=> auto_crossover_en == !$past(bus_req.wdata[6]) &&
      forced_crossover_select == $past(bus_req.wdata[7]);
  endproperty
  a_xo_wr: assert property (p_xo_wr) else $error("crossover write lost");
  property p_jab_wr; wr_pc |=> jabber_count_en == $past(bus_req.wdata[9]); endproperty
  a_jab_wr: assert property (p_jab_wr) else $error("jabber enable write lost");
endmodule
bind pep_phy_port_regs pep_phy_port_regs_monitor i_pep_phy_port_regs_monitor (.core_clk,
  .resetn, .bus_req, .rd_data, .phy_events, .link_status, .irq, .auto_crossover_en,
  .forced_crossover_select, .crossover_force_mdi, .crossover_force_mdix, .jabber_count_en);
`default_nettype wire

// ### tb/pep_phy_port_regs_tb_top.sv
// Self-checking bench for the PHY port event and status registers
`timescale 1ns/1ps
`default_nettype none
module pep_phy_port_regs_tb_top;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  pep_pkg::pep_bus_req_t bus_req = '0;
  pep_pkg::pep_event_t phy_events = '0;
  pep_pkg::pep_link_t link_status = '0;
  logic [15:0] rd_data, d, q;
  logic [7:0] en, ev;
  logic irq, auto_crossover_en, forced_crossover_select;
  logic crossover_force_mdi, crossover_force_mdix, jabber_count_en;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  pep_phy_port_regs i_pep_phy_port_regs (.core_clk, .resetn, .bus_req, .rd_data, .phy_events,
    .link_status, .irq, .auto_crossover_en, .forced_crossover_select, .crossover_force_mdi,
    .crossover_force_mdix, .jabber_count_en);
  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({15'h0000, got}, {15'h0000, exp});
  endtask
  // One bus cycle, launched right after an edge
  task automatic put(input logic w, input logic r, input logic [15:0] a, input logic [15:0] v);
    @(posedge core_clk) bus_req <= '{wr: w, rd: r, addr: a, wdata: v};
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    put(1'b1, 1'b0, a, v);
    put(1'b0, 1'b0, 16'h0000, 16'h0000);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    put(1'b0, 1'b1, a, 16'h0000);
    put(1'b0, 1'b0, 16'h0000, 16'h0000);
    #1 v = rd_data;
  endtask
  // Writable bits survive, live link state in 5:3, the rest reads zero
  function automatic logic [15:0] exp_pc(logic [15:0] v, pep_pkg::pep_link_t l);
    return (v & 16'hF380) | {10'h000, l, 3'h0};
  endfunction
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h54F1));
    link_status <= 3'($urandom);
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    rd(pep_pkg::PEP_ADDR_IRQ, q);
    chk_w(q, 16'h0000);
    rd(pep_pkg::PEP_ADDR_XOVER, q);
    chk_w(q, 16'h0000);
    chk_b(auto_crossover_en, 1'b1);
    rd(pep_pkg::PEP_ADDR_PHYCTL, q);
    chk_w(q, exp_pc(16'h0300, link_status));
    // Each event alone, even-numbered ones enabled and odd-numbered ones masked, then random mixes
    for (int k = 0; k < 24; k++) begin
      ev = (k < 8) ? 8'h01 << k : 8'($urandom);
      en = (k < 8) ? ((k % 2 == 1) ? ~ev : ev) : 8'($urandom);
      wr(pep_pkg::PEP_ADDR_IRQ, {en, 8'($urandom)});
      @(posedge core_clk) phy_events <= ev;
      @(posedge core_clk) phy_events <= '0;
      repeat (2) @(posedge core_clk);
      #1 chk_b(irq, |(en & ev));
      put(1'b0, 1'b1, pep_pkg::PEP_ADDR_IRQ, 16'h0000);
      put(1'b0, 1'b1, pep_pkg::PEP_ADDR_IRQ, 16'h0000);
      #1 chk_w(rd_data, {en, ev});
      put(1'b0, 1'b0, 16'h0000, 16'h0000);
      #1 chk_w(rd_data, {en, 8'h00});
      repeat (2) @(posedge core_clk);
      #1 chk_b(irq, 1'b0);
    end
    // Event in the clearing read's cycle must survive the clear
    put(1'b0, 1'b1, pep_pkg::PEP_ADDR_IRQ, 16'h0000);
    phy_events <= 8'h81;
    put(1'b0, 1'b0, 16'h0000, 16'h0000);
    phy_events <= '0;
    rd(pep_pkg::PEP_ADDR_IRQ, q);
    chk_w({8'h00, q[7:0]}, 16'h0081);
    // Every crossover mode, then random control words
    for (int k = 0; k < 8; k++) begin
      d = {8'($urandom), k[1:0], 6'($urandom)};
      wr(pep_pkg::PEP_ADDR_XOVER, d);
      rd(pep_pkg::PEP_ADDR_XOVER, q);
      chk_w(q, d);
      chk_b(auto_crossover_en, !d[6]);
      chk_b(forced_crossover_select, d[7]);
      chk_b(crossover_force_mdi, d[6] & d[7]);
      chk_b(crossover_force_mdix, d[6] & !d[7]);
      d = 16'($urandom);
      link_status <= 3'($urandom);
      wr(pep_pkg::PEP_ADDR_PHYCTL, d);
      rd(pep_pkg::PEP_ADDR_PHYCTL, q);
      chk_w(q, exp_pc(d, link_status));
      chk_b(jabber_count_en, d[9]);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
